/* src/scanned_key_cam.sv */
// Scanned-key associative memory: key registers scanned bit by bit,
// per-word compare cells, encoder networks and a scratchpad data section.
// Assumes the controller drives scan steps and keeps at most one match.
`timescale 1ns/10ps
`default_nettype none
module scanned_key_cam (
    input wire logic clock_i,
    input wire logic rst_i,
    // Key section scan port
    input wire logic [cam_pkg::KEY_AW-1:0] bit_addr_i,
    input wire logic key_wr_i,
    input wire logic [cam_pkg::WORDS-1:0] key_wr_word_i,
    input wire logic key_wr_bit_i,
    output logic [cam_pkg::WORDS-1:0] key_bits_o,
    // Search control
    input wire logic search_start_i,
    input wire logic search_step_i,
    input wire logic search_key_bit_i,
    output logic [cam_pkg::WORDS-1:0] match_o,
    output logic hit_o,
    output logic [cam_pkg::WORD_AW-1:0] word_addr_o,
    // Data section
    input wire logic write_en_i,
    input wire logic [cam_pkg::DATA_BITS-1:0] wr_data_i,
    output logic [cam_pkg::DATA_BITS-1:0] rd_data_o
);
    typedef struct packed {
        logic [cam_pkg::WORDS-1:0][cam_pkg::KEY_BITS-1:0] key;
        logic [cam_pkg::WORDS-1:0] match;
        logic [cam_pkg::DATA_BITS-1:0] rd_data;
    } state_t;

    state_t s_q;
    state_t s_d;
    logic [cam_pkg::DATA_BITS-1:0] data_mem [cam_pkg::WORDS];
    logic [cam_pkg::ELEMS-1:0][3:0] enc;
    logic [cam_pkg::WORDS-1:0] cmp_ok;
    logic [cam_pkg::WORD_AW-1:0] sel_word;
    logic [cam_pkg::ELEM_AW-1:0] sel_elem;
    logic any_hit;

    // Per-word compare cell: selected key bit against the broadcast bit
    for (genvar w = 0; w < cam_pkg::WORDS; w++) begin : g_cell
        assign cmp_ok[w] = (s_q.key[w][bit_addr_i] == search_key_bit_i);
        assign key_bits_o[w] = s_q.key[w][bit_addr_i];
    end

    // Address encoders, one per group of eight words
    for (genvar e = 0; e < cam_pkg::ELEMS; e++) begin : g_enc
        logic [7:0] c;
        assign c = s_q.match[e*8 +: 8];
        assign enc[e][0] = c[1] | c[3] | c[5] | c[7];
        assign enc[e][1] = c[2] | c[3] | c[6] | c[7];
        assign enc[e][2] = c[4] | c[5] | c[6] | c[7];
        assign enc[e][3] = enc[e][0] | enc[e][1] | enc[e][2] | c[0];
    end

    // Group select from the active encoder; relies on a single match
    always_comb begin
        sel_elem = '0;
        any_hit = 1'b0;
        for (int e = 0; e < cam_pkg::ELEMS; e++) begin
            if (enc[e][3]) begin
                sel_elem = e[cam_pkg::ELEM_AW-1:0];
                any_hit = 1'b1;
            end
        end
        sel_word = {sel_elem, enc[sel_elem][2:0]};
    end

    always_comb begin
        s_d = s_q;
        for (int w = 0; w < cam_pkg::WORDS; w++) begin
            if (key_wr_i && key_wr_word_i[w]) begin
                s_d.key[w][bit_addr_i] = key_wr_bit_i;
            end
        end
        if (search_start_i) begin
            // New search arms every word; the first step may come with it
            s_d.match = '1;
            if (search_step_i) begin
                s_d.match = cmp_ok;
            end
        end else if (search_step_i) begin
            s_d.match = s_q.match & cmp_ok;
        end
        s_d.rd_data = any_hit ? data_mem[sel_word] : '0;
    end

    // Match flags are armed during a search, so they only count as
    // a hit once the controller stops stepping; it gates that itself.
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            s_q.key <= '0;
            s_q.match <= cam_pkg::MATCH_RESET;
            s_q.rd_data <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Scratchpad write, whole word in parallel
    always_ff @(posedge clock_i) begin
        if (write_en_i && any_hit) begin
            data_mem[sel_word] <= wr_data_i;
        end
    end

    assign match_o = s_q.match;
    assign hit_o = any_hit;
    assign word_addr_o = sel_word;
    assign rd_data_o = s_q.rd_data;
endmodule
`default_nettype wire

/* src/cam_pkg.sv */
// Constants for the scanned-key associative memory.
// Assumes a single 100 MHz clock domain supplied by the system.
package cam_pkg;
    // Eight words per memory element, key bits in multiples of eight
    localparam int unsigned WORDS_PER_ELEM = 8;
    localparam int unsigned ELEMS = 2;
    localparam int unsigned WORDS = WORDS_PER_ELEM * ELEMS;
    localparam int unsigned KEY_ELEMS = 2;
    localparam int unsigned KEY_BITS = 8 * KEY_ELEMS;
    localparam int unsigned KEY_AW = $clog2(KEY_BITS);
    localparam int unsigned DATA_BITS = 8;
    localparam int unsigned WORD_AW = 4;
    localparam int unsigned ELEM_AW = 1;
    localparam logic [WORDS-1:0] MATCH_RESET = '0;
    localparam logic [KEY_AW-1:0] SCAN_RESET = '0;
endpackage

/* tb/cam_props.sv */
// Port checker; bound into scanned_key_cam from the bench top.
`timescale 1ns/10ps
`default_nettype none
module cam_props (input wire logic clock_i, rst_i, hit_o, write_en_i,
    search_start_i, search_step_i, search_key_bit_i,
    input wire logic [3:0] word_addr_o, input wire logic [7:0] wr_data_i,
    rd_data_o, input wire logic [15:0] key_bits_o, match_o);
default clocking @(posedge clock_i); endclocking
default disable iff (rst_i);
wire logic a = search_start_i, p = search_step_i, h = hit_o;
wire logic [15:0] m = match_o, q = ~(key_bits_o ^ {16{search_key_bit_i}});
a_hit_any: assert property (h == |m) else $error("hit");
a_start_arm: assert property (a && !p |=> &m) else $error("arm");
a_arm_cmp: assert property (a && p |=> m == $past(q)) else $error("1st");
a_step_and: assert property (p && !a |=> m == ($past(m) & $past(q)))
    else $error("and");
a_idle_hold: assert property (!a && !p |=> $stable(m))
    else $error("hold");
a_addr_enc: assert property ($onehot(m) |-> word_addr_o == {|m[15:8],
    |(m & 16'hf0f0), |(m & 16'hcccc), |(m & 16'haaaa)}) else $error("enc");
a_miss_rd: assert property (!h |=> rd_data_o == 0) else $error("rd");
a_wr_rd: assert property (write_en_i && h && !a && !p ##1 !a && !p |=>
    rd_data_o == $past(wr_data_i, 2)) else $error("wr");
c_hit: cover property (h);
c_first: cover property (a && p);
c_write: cover property (write_en_i && h);
endmodule
`default_nettype wire

/* tb/search_ctl.sv */
// Controller model: key shift register and scan counter, negedge driven.
`timescale 1ns/10ps
`default_nettype none
module search_ctl (input wire logic clock_i, go_i,
    input wire logic [15:0] key_i, mask_i, output logic busy_o = 0,
    output logic [3:0] addr_o = 0, output logic start_o, step_o, key_bit_o);
logic [15:0] r = 0, v = 0;
assign start_o = busy_o && addr_o == 0;
assign step_o = busy_o && v[addr_o];
assign key_bit_o = r[0];
always @(negedge clock_i) begin
    if (busy_o) {busy_o, addr_o, r} <= {addr_o != 15, addr_o + 4'h1, r >> 1};
    else if (go_i) {busy_o, r, v} <= {1'b1, key_i, mask_i};
end
endmodule
`default_nettype wire

/* tb/tb_scanned_key_cam.sv */
// Bench: unique random keys, masked searches, writes; model drives scans.
`timescale 1ns/10ps
`default_nettype none
module tb_scanned_key_cam;
logic clock_i = 0, rst_i = 1, key_wr_i = 0, key_wr_bit_i = 0, g = 0, b;
logic write_en_i = 0, search_start_i, search_step_i, search_key_bit_i, hit_o;
logic [3:0] bit_addr_i, word_addr_o, c, a = 0;
logic [7:0] wr_data_i = 0, rd_data_o;
logic [15:0] key_wr_word_i = 0, key_bits_o, match_o, k = 0, s = 0, e, y [16];
int fails = 0, num_checks = 0, n = 0, t;
always #5 clock_i = ~clock_i;
assign bit_addr_i = b ? c : a;
search_ctl ctl (.clock_i, .go_i(g), .key_i(k), .mask_i(s), .busy_o(b),
    .addr_o(c), .start_o(search_start_i), .step_o(search_step_i),
    .key_bit_o(search_key_bit_i));
scanned_key_cam dut (.*);
task chk(input string w, input logic [15:0] x, z);
    num_checks++;
    if (x !== z) $display("CHECK FAILED %s exp %h got %h", w, x, z);
    if (x !== z) fails++;
endtask
task print_verdict;
    if (fails == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
endtask
always @(posedge clock_i) if (++n > 3000) begin fails++; print_verdict; end
initial begin
    void'($urandom(32'h4dcd649f));
    foreach (y[i]) y[i] = {12'($urandom), 4'(i)};
    repeat (2) @(negedge clock_i);
    rst_i <= 0;
    for (int i = 0; i < 32; i++) begin
        {a, key_wr_bit_i, key_wr_i} <= {4'(i / 2), i[0], 1'b1};
        foreach (y[j]) key_wr_word_i[j] <= y[j][i / 2] == i[0];
        @(negedge clock_i);
    end
    key_wr_i <= 0;
    repeat (40) begin
        t = $urandom_range(15);
        s = t[0] ? 16'hffff : 16'($urandom) | 16'h1f;
        k = y[t] ^ (t[1] ? 16'h10 : 16'h0);
        foreach (y[j]) e[j] = ((y[j] ^ k) & s) == 0;
        g <= 1;
        @(negedge clock_i);
        g <= 0;
        @(negedge clock_i);
        while (b) @(negedge clock_i);
        chk("match", e, match_o);
        chk("hit", 16'(|e), 16'(hit_o));
        if (hit_o === 1'b1) chk("addr", 16'(t), 16'(word_addr_o));
        {wr_data_i, write_en_i} <= {8'($urandom), 1'b1};
        @(negedge clock_i);
        write_en_i <= 0;
        @(negedge clock_i);
        chk("rd", |e ? 16'(wr_data_i) : 16'h0, 16'(rd_data_o));
    end
    print_verdict;
end
endmodule
bind scanned_key_cam cam_props props (.*);
`default_nettype wire
